// File: core/tis_core.sv
// threshold compare and sticky interrupt status of the light / proximity sensor
// assumes the bus front end presents one-cycle byte reads and writes
// How it works
// [RULE1] low threshold is two bytes, upper at 0x8a, lower at 0x8b
// [RULE2] high threshold is two bytes, upper at 0x8c, lower at 0x8d
// [RULE3] all four threshold bytes read and write; higher address holds bits 7:0
// [RULE4] status at 0x8e: bit3 prox, bit2 ambient, bit1 below, bit0 above
// [RULE5] below flag sets when monitored result crosses under low threshold
// [RULE6] above flag sets when monitored result exceeds high threshold
// [RULE7] thresholds watch proximity or ambient, chosen by the select bit
// [RULE8] a raised flag stays at one whatever later results are
// [RULE9] a flag clears only when host writes one to its bit
// [RULE10] interrupt pin low while any flag is one
// [RULE11] threshold flag needs 1 to 128 consecutive crossings, code doubling
// [RULE12] threshold flags raise only when threshold enable is set
// [RULE13] proximity ready flag sets on done only when enabled
// [RULE14] ambient ready flag sets on done only when enabled
// [RULE15] crossing is strictly above high or strictly below low, 16 bits
// [RULE16] writing zero or unused bits leaves status unchanged
module tis_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input tis_pkg::tis_req_s req,
    output logic [7:0] rdata,
    // measurement engine
    input tis_pkg::tis_meas_s meas,
    // interrupt pad
    output logic int_n
);
    import tis_pkg::*;

    // control and threshold registers
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [15:0] low_thresh;
    logic [15:0] next_low_thresh;
    logic [15:0] high_thresh;
    logic [15:0] next_high_thresh;
    // sticky status and pad
    logic [3:0] flags;
    logic [3:0] next_flags;
    logic next_int_n;
    // read path
    logic [7:0] next_rdata;
    // compare path
    logic mon_sample;
    logic [15:0] mon_value;
    logic is_below;
    logic is_above;
    logic trip_below;
    logic trip_above;
    // flag events and host clears of this cycle
    logic [3:0] set_vec;
    logic [3:0] clr_vec;

    function automatic logic hit(input tis_req_s r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    // one byte of a threshold word, upper picks bits 15:8
    function automatic logic [7:0] thr_byte(input logic [15:0] t, input logic upper);
        thr_byte = upper ? t[15:8] : t[7:0];
    endfunction

    // interrupt control register
    // bit 4 has no function but reads back as written
    always_comb begin
        next_ctrl = ctrl;
        if (hit(req, ADDR_INT_CTRL)) begin
            next_ctrl = req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl <= CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // threshold bytes
    // a word changes in two separate writes, so a result compared in between meets a
    // half-updated limit; software should clear the threshold enable while reprogramming
    always_comb begin
        next_low_thresh = low_thresh;
        next_high_thresh = high_thresh;
        if (hit(req, ADDR_LOW_UPPER)) begin
            next_low_thresh[15:8] = req.wdata; // see [RULE1]
        end
        if (hit(req, ADDR_LOW_LOWER)) begin
            next_low_thresh[7:0] = req.wdata; // see [RULE3]
        end
        if (hit(req, ADDR_HIGH_UPPER)) begin
            next_high_thresh[15:8] = req.wdata; // see [RULE2]
        end
        if (hit(req, ADDR_HIGH_LOWER)) begin
            next_high_thresh[7:0] = req.wdata; // see [RULE3]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            low_thresh <= THRESH_RESET;
            high_thresh <= THRESH_RESET;
        end else begin
            low_thresh <= next_low_thresh;
            high_thresh <= next_high_thresh;
        end
    end

    // monitored measurement selection and compare
    always_comb begin
        if (ctrl[CTRL_THR_SEL]) begin
            mon_sample = meas.amb_done; // see [RULE7]
            mon_value = meas.amb_result;
        end else begin
            mon_sample = meas.prox_done; // see [RULE7]
            mon_value = meas.prox_result;
        end
        is_below = mon_value < low_thresh; // see [RULE15]
        is_above = mon_value > high_thresh; // see [RULE15]
    end

    // separate run counters so alternating crossings do not add up; a count code
    // lowered mid-run keeps the running count, which then trips on the next crossing if that count is at least the new need minus one
    tis_persist u_below (
        .core_clk(core_clk),
        .srst(srst),
        .sample(mon_sample),
        .beyond(is_below),
        .count_code(ctrl[CTRL_COUNT_LSB +: 3]),
        .trip(trip_below)
    );

    tis_persist u_above (
        .core_clk(core_clk),
        .srst(srst),
        .sample(mon_sample),
        .beyond(is_above),
        .count_code(ctrl[CTRL_COUNT_LSB +: 3]),
        .trip(trip_above)
    );

    // status flags: set wins over a same-cycle clear, so no event is lost to a late ack
    always_comb begin
        set_vec = 4'h0;
        set_vec[FLAG_PROX_READY] = meas.prox_done && ctrl[CTRL_PROX_EN]; // see [RULE13]
        set_vec[FLAG_AMB_READY] = meas.amb_done && ctrl[CTRL_AMB_EN]; // see [RULE14]
        set_vec[FLAG_BELOW] = trip_below && ctrl[CTRL_THR_EN]; // see [RULE5] [RULE12]
        set_vec[FLAG_ABOVE] = trip_above && ctrl[CTRL_THR_EN]; // see [RULE6] [RULE12]
        // writes of zero and of bits 7:4 clear nothing
        clr_vec = 4'h0;
        if (hit(req, ADDR_INT_FLAGS)) begin
            clr_vec = req.wdata[3:0] & FLAG_MASK; // see [RULE9] [RULE16]
        end
        next_flags = (flags & ~clr_vec) | set_vec; // see [RULE8]
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // pad follows the flags of the same edge, with no extra cycle of latency;
    // it is active low and released while every flag is clear
    always_comb begin
        next_int_n = ~(|next_flags); // see [RULE10]
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            int_n <= 1'b1;
        end else begin
            int_n <= next_int_n;
        end
    end

    // read data registered one cycle after the read request; it holds between reads
    always_comb begin
        next_rdata = rdata;
        if (req.rd) begin
            case (req.addr)
                ADDR_INT_CTRL: begin
                    next_rdata = ctrl;
                end
                ADDR_LOW_UPPER: begin
                    next_rdata = thr_byte(low_thresh, 1'b1);
                end
                ADDR_LOW_LOWER: begin
                    next_rdata = thr_byte(low_thresh, 1'b0);
                end
                ADDR_HIGH_UPPER: begin
                    next_rdata = thr_byte(high_thresh, 1'b1);
                end
                ADDR_HIGH_LOWER: begin
                    next_rdata = thr_byte(high_thresh, 1'b0);
                end
                ADDR_INT_FLAGS: begin
                    // bits 7:4 hold no flag and read as zero
                    next_rdata = {4'h0, flags}; // see [RULE4]
                end
                default: begin
                    // unmapped addresses read as zero
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule // tis_core

// File: inc/tis_pkg.sv
// shared constants and types of the threshold / interrupt status block
// assumes one core clock and a byte-wide register port driven by the bus front end
package tis_pkg;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h89;
    localparam logic [7:0] ADDR_LOW_UPPER = 8'h8a;
    localparam logic [7:0] ADDR_LOW_LOWER = 8'h8b;
    localparam logic [7:0] ADDR_HIGH_UPPER = 8'h8c;
    localparam logic [7:0] ADDR_HIGH_LOWER = 8'h8d;
    localparam logic [7:0] ADDR_INT_FLAGS = 8'h8e;
    // interrupt_flags field positions
    localparam int FLAG_PROX_READY = 3;
    localparam int FLAG_AMB_READY = 2;
    localparam int FLAG_BELOW = 1;
    localparam int FLAG_ABOVE = 0;
    localparam logic [3:0] FLAG_MASK = 4'hf;
    // interrupt control field positions
    localparam int CTRL_COUNT_LSB = 5;
    localparam int CTRL_PROX_EN = 3;
    localparam int CTRL_AMB_EN = 2;
    localparam int CTRL_THR_EN = 1;
    localparam int CTRL_THR_SEL = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] THRESH_RESET = 16'h0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tis_req_s;

    // completed measurement report
    typedef struct packed {
        logic prox_done;
        logic amb_done;
        logic [15:0] prox_result;
        logic [15:0] amb_result;
    } tis_meas_s;
endpackage

// File: core/tis_persist.sv
// consecutive-crossing counter for threshold flags
// assumes one measurement strobe per completed monitored measurement
module tis_persist (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // measurement stream
    input wire logic sample,
    input wire logic beyond,
    input wire logic [2:0] count_code,
    // result
    output logic trip
);
    import tis_pkg::*;

    logic [7:0] run;
    logic [7:0] next_run;
    logic [7:0] need;

    always_comb begin
        need = 8'h01 << count_code;
        next_run = run;
        trip = 1'b0;
        if (sample) begin
            if (!beyond) begin
                next_run = 8'h00;
            end else if (run + 8'h01 >= need) begin
                trip = 1'b1; // see [RULE11]
                next_run = 8'h00;
            end else begin
                next_run = run + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            run <= 8'h00;
        end else begin
            run <= next_run;
        end
    end
endmodule // tis_persist

// File: dv/tis_core_sva.sv
// checker: port-level relations of the threshold and status block
// assumes it is bound to tis_core and sees only its ports
module tis_core_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port, measurements, pad
    input wire tis_pkg::tis_req_s req,
    input wire logic [7:0] rdata,
    input wire tis_pkg::tis_meas_s meas,
    input wire logic int_n
);
    timeunit 1ns;
    timeprecision 100ps;
    import tis_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_wr_rd;
        req.wr && req.addr inside {[8'h8a:8'h8d]} ##1
            req.rd && !req.wr && req.addr == $past(req.addr);
    endsequence
    property p_rst; disable iff (1'b0) srst |=> int_n && rdata == 8'h00; endproperty
    property p_thr; s_wr_rd |=> rdata == $past(req.wdata, 2); endproperty
    property p_unm; req.rd && !(req.addr inside {[8'h89:8'h8e]}) |=> rdata == 8'h00; endproperty
    property p_top; req.rd && req.addr == 8'h8e |=> rdata[7:4] == 4'h0; endproperty
    property p_pin; req.rd && req.addr == 8'h8e |=> (rdata[3:0] != 4'h0) == !$past(int_n);
    endproperty
    property p_fall; $fell(int_n) |-> $past(meas.prox_done || meas.amb_done); endproperty
    property p_rise; $rose(int_n) && !$past(srst) |-> $past(req.wr && req.addr == 8'h8e);
    endproperty
    property p_hold; !int_n && !(req.wr && req.addr == 8'h8e && req.wdata[3:0] != 4'h0)
        |=> !int_n; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_thr: assert property (p_thr) else $error("threshold byte lost");
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    a_top: assert property (p_top) else $error("unused status bits set");
    a_pin: assert property (p_pin) else $error("pad disagrees with flags");
    a_fall: assert property (p_fall) else $error("flag set without result");
    a_rise: assert property (p_rise) else $error("flag cleared without write");
    a_hold: assert property (p_hold) else $error("flag not sticky");
endmodule // tis_core_sva
bind tis_core tis_core_sva tis_core_sva_inst (.core_clk(core_clk), .srst(srst), .req(req),
    .rdata(rdata), .meas(meas), .int_n(int_n));

// File: dv/tis_host.sv
// host model: issues byte reads and writes on the register port
// assumes the bench calls op once per cycle
module tis_host (
    // clock
    input wire logic core_clk,
    // register port
    output tis_pkg::tis_req_s req
);
    timeunit 1ns;
    timeprecision 100ps;
    import tis_pkg::*;
    initial req = '0;
    // change just after the edge, hold until the next edge takes it
    task automatic op(bit w, bit r, bit [7:0] a, bit [7:0] d);
        @(posedge core_clk);
        #1;
        req = '{w, r, a, d};
    endtask
endmodule // tis_host

// File: dv/threshold_interrupt_status_bench.sv
// bench: integer model of registers, flags and run counters checked every cycle
// assumes tis_core with the tis_host model on the register port
module threshold_interrupt_status_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import tis_pkg::*;
    logic core_clk = 0;
    logic srst = 1;
    tis_req_s req;
    tis_meas_s meas = '0;
    logic [7:0] rdata;
    logic int_n;
    int n_mismatch = 0, compares = 0, cycles = 0, th[4], ctrl, fl, cl, ch, ex, pend;
    bit [31:0] s = 32'd74972, v;
    initial forever #10 core_clk = ~core_clk;
    tis_host tis_host_inst (.core_clk(core_clk), .req(req));
    tis_core tis_core_inst (.core_clk(core_clk), .srst(srst), .req(req), .rdata(rdata),
        .meas(meas), .int_n(int_n));
    function automatic bit [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk_rd(int e);
        compares++;
        if (rdata !== e[7:0]) begin
            n_mismatch++;
            $display("unexpected rdata expected %h seen %h", e[7:0], rdata);
        end
    endtask
    task automatic chk_int(bit e);
        compares++;
        if (int_n !== e) begin
            n_mismatch++;
            $display("unexpected int_n expected %b seen %b", e, int_n);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge core_clk) if (++cycles == 20000) begin
        n_mismatch++;
        complete_run();
    end
    task automatic step(bit r0, bit w, bit r, bit [7:0] a, bit [7:0] d, bit pd, bit ad);
        bit [31:0] m;
        int res, n, st;
        tis_host_inst.op(w, r, a, d);
        chk_int(fl == 0);
        if (pend) chk_rd(ex);
        m = rnd();
        meas = '{pd, ad, m[15:0], m[31:16]};
        srst = r0;
        pend = r | r0;
        ex = a == 8'h89 ? ctrl : a inside {[8'h8a:8'h8d]} ? th[a - 8'h8a] : a == 8'h8e ? fl : 0;
        res = ctrl[0] ? m[31:16] : m[15:0];
        n = 1 << ctrl[7:5];
        st = 0;
        if (ctrl[0] ? ad : pd) begin
            cl = res < th[0] * 256 + th[1] ? cl + 1 : 0;
            ch = res > th[2] * 256 + th[3] ? ch + 1 : 0;
            if (cl >= n) begin
                cl = 0;
                st |= ctrl[1] << 1;
            end
            if (ch >= n) begin
                ch = 0;
                st |= ctrl[1];
            end
        end
        st |= (pd & ctrl[3]) << 3 | (ad & ctrl[2]) << 2;
        if (w && a == 8'h8e) fl &= ~d;
        else if (w && a == 8'h89) ctrl = d;
        else if (w && a inside {[8'h8a:8'h8d]}) th[a - 8'h8a] = d;
        fl = (fl | st) & 15;
        if (r0) begin
            ex = 0;
            {ctrl, fl, cl, ch} = '0;
            th = '{0, 0, 0, 0};
        end
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        for (int k = 0; k < 40; k++) begin
            step(1, 0, 0, 0, 0, 0, 0);
            // each threshold byte is read back in the cycle right after its write
            for (int i = 0; i < 4; i++) begin
                step(0, 1, 0, 8'(8'h8a + i), 8'(rnd()), 0, 0);
                step(0, 0, 1, 8'(8'h8a + i), 0, 0, 0);
            end
            v = rnd() & 32'h6f;
            if (v[6:5] != 0) v[1] = 1;
            step(0, 1, 0, 8'h89, v[7:0], 0, 0);
            for (int a = 8'h88; a < 8'h90; a++) step(0, 0, 1, 8'(a), 0, 0, 0);
            repeat (30) begin
                v = rnd();
                step(0, v[4], v[5], 8'h8e, v[15:8], v[0], v[1]);
            end
        end
        // longest count code: zero high limit, so nearly every proximity result crosses
        step(1, 0, 0, 0, 0, 0, 0);
        step(0, 1, 0, 8'h89, 8'he2, 0, 0);
        repeat (130) step(0, 0, 0, 0, 0, 1, 0);
        step(0, 0, 1, 8'h8e, 0, 0, 0);
        step(0, 1, 0, 8'h8e, 8'h01, 0, 0);
        step(0, 0, 1, 8'h8e, 0, 0, 0);
        step(0, 0, 0, 0, 0, 0, 0);
        complete_run();
    end
endmodule // threshold_interrupt_status_bench
